// *** common/dmau_pkg.sv ***
// ============================================================
// data memory address unit: shared constants and decoders
package dmau_pkg;

   // ============================================================
   // geometry
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   localparam int OFF_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_PTR = 3;
   localparam int NUM_BANKS = 16;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] SFR_BANK = 4'hF;

   // ============================================================
   // special function addresses; each pointer owns an aligned block of eight
   localparam logic [11:0] PTR_BASE [0:2] = '{12'hFE8, 12'hFE0, 12'hFD8};
   localparam logic [2:0] SUB_DEREF = 3'h7;
   localparam logic [2:0] SUB_POST_INC = 3'h6;
   localparam logic [2:0] SUB_POST_DEC = 3'h5;
   localparam logic [2:0] SUB_PRE_INC = 3'h4;
   localparam logic [2:0] SUB_INDEXED = 3'h3;
   localparam logic [2:0] SUB_HIGH = 3'h2;
   localparam logic [2:0] SUB_LOW = 3'h1;
   localparam logic [11:0] BANK_SELECT_ADDR = 12'hFD7;

   // ============================================================
   // software register port
   localparam logic [2:0] REG_BANK_SELECT = 3'h0;
   localparam logic [2:0] REG_PTR0_LOW = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h7;
   localparam int ST_UNIMPL = 0;
   localparam int ST_PORT_HIT = 1;

   // ============================================================
   // reset values
   localparam logic [3:0] BANK_SELECT_RESET = 4'h0;
   localparam logic [11:0] PTR_RESET = 12'h000;

   typedef enum logic [4:0] {
      DMAU_M_DEREF = 5'b00001,
      DMAU_M_POST_DEC = 5'b00010,
      DMAU_M_POST_INC = 5'b00100,
      DMAU_M_PRE_INC = 5'b01000,
      DMAU_M_INDEXED = 5'b10000
   } dmau_mode_e;

   function automatic logic dmau_is_port(input logic [11:0] a);
      logic hit;
      hit = 1'b0;
      for (int n = 0; n < NUM_PTR; n++) begin
         if (a[11:3] == PTR_BASE[n][11:3] && a[2:0] >= SUB_INDEXED) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic [1:0] dmau_port_index(input logic [11:0] a);
      logic [1:0] idx;
      idx = 2'h0;
      for (int n = 0; n < NUM_PTR; n++) begin
         if (a[11:3] == PTR_BASE[n][11:3]) begin
            idx = 2'(n);
         end
      end
      return idx;
   endfunction

   function automatic dmau_mode_e dmau_port_mode(input logic [2:0] sub);
      dmau_mode_e m;
      case (sub)
         SUB_POST_DEC: m = DMAU_M_POST_DEC;
         SUB_POST_INC: m = DMAU_M_POST_INC;
         SUB_PRE_INC: m = DMAU_M_PRE_INC;
         SUB_INDEXED: m = DMAU_M_INDEXED;
         default: m = DMAU_M_DEREF;
      endcase
      return m;
   endfunction

endpackage

// *** rtl/dmau_direct.sv ***
`timescale 1ns/1ps
// ============================================================
// direct operand address formation
module dmau_direct
   import dmau_pkg::*;
(
   // operand
   input wire logic [3:0] bank_i,
   input wire logic access_i,
   input wire logic [7:0] offset_i,
   input wire logic abs_i,
   input wire logic [11:0] abs_addr_i,
   // result
   output logic [11:0] addr_o
);
   import dmau_pkg::*;

   logic [3:0] access_bank;
   logic [3:0] bank;

   // low half of the window is bank 0, high half the sfr bank
   assign access_bank = (offset_i < ACCESS_SPLIT) ? ACCESS_LOW_BANK : SFR_BANK;
   assign bank = access_i ? bank_i : access_bank;
   // full-address moves never look at the bank select
   assign addr_o = abs_i ? abs_addr_i : {bank, offset_i};

endmodule

// *** rtl/dmau_pointer.sv ***
`timescale 1ns/1ps
// ============================================================
// one 12-bit data pointer with its auto-modify logic
module dmau_pointer
   import dmau_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // access control
   input wire dmau_pkg::dmau_mode_e mode_i,
   input wire logic step_i,
   input wire logic load_lo_i,
   input wire logic load_hi_i,
   input wire logic [7:0] load_data_i,
   input wire logic [7:0] wacc_i,
   // pointer state
   output logic [11:0] ptr_o,
   output logic [11:0] eff_o
);
   import dmau_pkg::*;

   logic [11:0] ptr_q;
   logic [11:0] ptr_d;
   logic [11:0] inc_w;
   logic [11:0] dec_w;
   logic [11:0] stepped_w;
   logic [11:0] loaded_w;

   // carries and borrows cross the byte boundary by using full 12-bit adders for inc_w and dec_w
   assign inc_w = ptr_q + 12'h001;
   assign dec_w = ptr_q - 12'h001;
   assign stepped_w = (mode_i == DMAU_M_POST_DEC) ? dec_w :
                      (mode_i == DMAU_M_POST_INC || mode_i == DMAU_M_PRE_INC) ? inc_w : ptr_q;
   assign loaded_w = {load_hi_i ? load_data_i[3:0] : ptr_q[11:8], load_lo_i ? load_data_i : ptr_q[7:0]};
   // a byte write cancels the auto-modify of the same pointer
   assign ptr_d = (load_lo_i || load_hi_i) ? loaded_w : (step_i ? stepped_w : ptr_q);
   assign eff_o = (mode_i == DMAU_M_PRE_INC) ? inc_w :
                  (mode_i == DMAU_M_INDEXED) ? ptr_q + {{4{wacc_i[7]}}, wacc_i} : ptr_q;
   assign ptr_o = ptr_q;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ptr_q <= PTR_RESET;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // ============================================================
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   AST_PTR_POST_INC: assert property (step_i && mode_i == DMAU_M_POST_INC && !load_lo_i && !load_hi_i
      |=> ptr_q == $past(ptr_q) + 12'h001) else $error("pointer did not increment");
   AST_PTR_POST_DEC: assert property (step_i && mode_i == DMAU_M_POST_DEC && !load_lo_i && !load_hi_i
      |=> ptr_q == $past(ptr_q) - 12'h001) else $error("pointer did not decrement");
   AST_PTR_LOAD_WINS: assert property (step_i && load_lo_i
      |=> ptr_q[7:0] == $past(load_data_i)) else $error("auto-modify beat a byte write");
   AST_PTR_INDEXED_HOLD: assert property (mode_i == DMAU_M_INDEXED && !load_lo_i && !load_hi_i
      |=> $stable(ptr_q)) else $error("indexed access moved the pointer");

endmodule

// *** rtl/dmau_addr_unit.sv ***
`timescale 1ns/1ps
// ============================================================
// data memory address unit
// Notes on behaviour
// - access bank is bank0 low plus bank15 high
// - instruction access bit picks banked or access
// - access window is 256 bytes in two halves, 000-07F and F80-FFF
// - sixteen banks; bank select supplies address top
// - bank select upper nibble reads zero, ignores writes
// - unimplemented bank reads zero, drops writes
// - each bank holds 256 bytes, 8-bit offset
// - file-to-file move uses full address, no bank
// - port access goes to pointed location, stores nothing
// - three independent 12-bit pointers over 4096 bytes
// - indirect read of a port gives zero, zero flag
// - indirect write to a port is a no-op
// - five ports per pointer select five behaviours
// - pointer auto-modify never touches status flags
// - increment and decrement span all 12 bits
// - indexed port adds signed accumulator, modifies nothing
// - byte write beats pointer auto-modify
module dmau_addr_unit
   import dmau_pkg::*;
#(
   parameter int DATA_BANKS = 16
)(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // operand request from the datapath
   input wire logic op_valid_i,
   input wire logic op_write_i,
   input wire logic op_access_i,
   input wire logic op_abs_i,
   input wire logic [dmau_pkg::OFF_W-1:0] op_offset_i,
   input wire logic [dmau_pkg::ADDR_W-1:0] op_abs_addr_i,
   input wire logic [dmau_pkg::DATA_W-1:0] op_wdata_i,
   input wire logic [dmau_pkg::DATA_W-1:0] wacc_i,
   // answer to the datapath
   output logic op_rvalid_o,
   output logic [dmau_pkg::DATA_W-1:0] op_rdata_o,
   output logic op_zero_o,
   output logic op_status_keep_o,
   // data ram
   output logic [dmau_pkg::ADDR_W-1:0] mem_addr_o,
   output logic mem_we_o,
   output logic mem_re_o,
   output logic [dmau_pkg::DATA_W-1:0] mem_wdata_o,
   input wire logic [dmau_pkg::DATA_W-1:0] mem_rdata_i,
   // software register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [dmau_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [dmau_pkg::DATA_W-1:0] reg_rdata_o
);
   import dmau_pkg::*;

   generate
      if (DATA_BANKS < 1 || DATA_BANKS > NUM_BANKS) begin : g_bad_banks
         $error("DATA_BANKS must lie in 1..16");
      end
   endgenerate

   localparam logic [1:0] SRC_MEM = 2'h0;
   localparam logic [1:0] SRC_INT = 2'h1;
   localparam logic [1:0] SRC_ZERO = 2'h2;

   // ============================================================
   // state
   logic [3:0] bank_select_q;
   logic [ADDR_W-1:0] mem_addr_q;
   logic mem_we_q;
   logic mem_re_q;
   logic [DATA_W-1:0] mem_wdata_q;
   logic rd_q;
   logic [1:0] rd_src_q;
   logic [DATA_W-1:0] int_data_q;
   logic op_rvalid_q;
   logic [DATA_W-1:0] op_rdata_q;
   logic op_zero_q;
   logic status_keep_q;
   logic last_unimpl_q;
   logic last_port_q;
   logic [DATA_W-1:0] reg_rdata_q;

   // ============================================================
   // address resolution
   logic [ADDR_W-1:0] dir_addr;
   logic hit_port;
   logic [1:0] port_sel;
   dmau_mode_e port_mode;
   logic [ADDR_W-1:0] eff_w [0:NUM_PTR-1];
   logic [ADDR_W-1:0] ptr_w [0:NUM_PTR-1];
   logic [ADDR_W-1:0] ind_addr;
   logic [ADDR_W-1:0] final_addr;
   logic ind_to_port;
   logic unimpl;
   logic kill;

   dmau_direct u_direct (
      .bank_i(bank_select_q),
      .access_i(op_access_i),
      .offset_i(op_offset_i),
      .abs_i(op_abs_i),
      .abs_addr_i(op_abs_addr_i),
      .addr_o(dir_addr)
   );

   assign hit_port = dmau_is_port(dir_addr);
   assign port_sel = dmau_port_index(dir_addr);
   assign port_mode = dmau_port_mode(dir_addr[2:0]);
   assign ind_addr = eff_w[port_sel];
   // the port is only a redirect; the access lands where the pointer says
   assign final_addr = hit_port ? ind_addr : dir_addr;
   assign ind_to_port = hit_port && dmau_is_port(ind_addr);
   // sfr bank always exists; lower banks only up to DATA_BANKS
   assign unimpl = ({1'b0, final_addr[11:8]} >= 5'(DATA_BANKS)) && (final_addr[11:8] != SFR_BANK);
   assign kill = ind_to_port || unimpl;

   // ============================================================
   // internal special function registers
   logic bsel_hit;
   logic [NUM_PTR-1:0] lo_hit;
   logic [NUM_PTR-1:0] hi_hit;
   logic [DATA_W-1:0] ptr_rd [0:NUM_PTR-1];
   logic int_hit;
   logic [DATA_W-1:0] int_data;
   logic dp_wr;
   logic dp_int_wr;
   logic reg_wr_ok;
   logic [NUM_PTR-1:0] load_lo;
   logic [NUM_PTR-1:0] load_hi;
   logic [DATA_W-1:0] load_data;
   logic [NUM_PTR-1:0] step;
   logic bsel_wr;
   logic [3:0] bsel_wdata;

   assign dp_wr = op_valid_i && op_write_i && !kill;
   assign bsel_hit = final_addr == BANK_SELECT_ADDR;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
         logic [2:0] reg_lo_idx;
         assign reg_lo_idx = REG_PTR0_LOW + 3'(2 * gi);
         assign lo_hit[gi] = final_addr == {PTR_BASE[gi][11:3], SUB_LOW};
         assign hi_hit[gi] = final_addr == {PTR_BASE[gi][11:3], SUB_HIGH};
         assign ptr_rd[gi] = lo_hit[gi] ? ptr_w[gi][7:0] :
                             hi_hit[gi] ? {4'h0, ptr_w[gi][11:8]} : 8'h00;
         assign load_lo[gi] = (dp_wr && lo_hit[gi]) || (reg_wr_ok && reg_addr_i == reg_lo_idx);
         assign load_hi[gi] = (dp_wr && hi_hit[gi]) || (reg_wr_ok && reg_addr_i == reg_lo_idx + 3'h1);
         // pointer moves never feed the status flags
         assign step[gi] = op_valid_i && hit_port && port_sel == 2'(gi)
                           && (port_mode == DMAU_M_POST_DEC || port_mode == DMAU_M_POST_INC
                               || port_mode == DMAU_M_PRE_INC);

         dmau_pointer u_ptr (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .mode_i(port_mode),
            .step_i(step[gi]),
            .load_lo_i(load_lo[gi]),
            .load_hi_i(load_hi[gi]),
            .load_data_i(load_data),
            .wacc_i(wacc_i),
            .ptr_o(ptr_w[gi]),
            .eff_o(eff_w[gi])
         );
      end
   endgenerate

   assign int_hit = bsel_hit || (|lo_hit) || (|hi_hit);
   assign int_data = bsel_hit ? {4'h0, bank_select_q} : (ptr_rd[0] | ptr_rd[1] | ptr_rd[2]);
   assign dp_int_wr = dp_wr && int_hit;
   // a datapath write to an internal register wins; a clashing port write is lost
   assign reg_wr_ok = reg_we_i && !dp_int_wr;
   assign load_data = dp_int_wr ? op_wdata_i : reg_wdata_i;
   assign bsel_wr = (dp_wr && bsel_hit) || (reg_wr_ok && reg_addr_i == REG_BANK_SELECT);
   // only the low nibble exists, so upper writes vanish
   assign bsel_wdata = load_data[3:0];

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bank_select_q <= BANK_SELECT_RESET;
      end else if (bsel_wr) begin
         bank_select_q <= bsel_wdata;
      end
   end

   // ============================================================
   // memory request stage
   logic [1:0] rd_src_d;

   assign rd_src_d = kill ? SRC_ZERO : (int_hit ? SRC_INT : SRC_MEM);

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         mem_addr_q <= '0;
         mem_we_q <= 1'b0;
         mem_re_q <= 1'b0;
         mem_wdata_q <= '0;
         rd_q <= 1'b0;
         rd_src_q <= SRC_MEM;
         int_data_q <= '0;
         status_keep_q <= 1'b0;
      end else begin
         if (op_valid_i) begin
            mem_addr_q <= final_addr;
            mem_wdata_q <= op_wdata_i;
            rd_src_q <= rd_src_d;
            int_data_q <= int_data;
         end
         mem_we_q <= dp_wr && !int_hit;
         mem_re_q <= op_valid_i && !op_write_i && !kill && !int_hit;
         rd_q <= op_valid_i && !op_write_i;
         status_keep_q <= op_valid_i && op_write_i && ind_to_port;
      end
   end

   // ============================================================
   // answer stage
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         op_rvalid_q <= 1'b0;
         op_rdata_q <= '0;
         op_zero_q <= 1'b0;
      end else begin
         op_rvalid_q <= rd_q;
         if (rd_q) begin
            op_rdata_q <= (rd_src_q == SRC_MEM) ? mem_rdata_i :
                          (rd_src_q == SRC_INT) ? int_data_q : 8'h00;
         end
         // forced zero flag only for a port read through a pointer
         op_zero_q <= rd_q && rd_src_q == SRC_ZERO && last_port_q;
      end
   end

   // ============================================================
   // software register port
   logic [DATA_W-1:0] reg_rd_mux;
   logic [2:0] reg_ptr_off;

   assign reg_ptr_off = reg_addr_i - REG_PTR0_LOW;
   assign reg_rd_mux = (reg_addr_i == REG_BANK_SELECT) ? {4'h0, bank_select_q} :
                       (reg_addr_i == REG_STATUS) ? {6'h00, last_port_q, last_unimpl_q} :
                       reg_ptr_off[0] ? {4'h0, ptr_w[reg_ptr_off[2:1]][11:8]} : ptr_w[reg_ptr_off[2:1]][7:0];

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_q <= '0;
         last_unimpl_q <= 1'b0;
         last_port_q <= 1'b0;
      end else begin
         if (reg_re_i) begin
            reg_rdata_q <= reg_rd_mux;
         end
         if (op_valid_i) begin
            last_unimpl_q <= unimpl;
            last_port_q <= ind_to_port;
         end
      end
   end

   assign op_rvalid_o = op_rvalid_q;
   assign op_rdata_o = op_rdata_q;
   assign op_zero_o = op_zero_q;
   assign op_status_keep_o = status_keep_q;
   assign mem_addr_o = mem_addr_q;
   assign mem_we_o = mem_we_q;
   assign mem_re_o = mem_re_q;
   assign mem_wdata_o = mem_wdata_q;
   assign reg_rdata_o = reg_rdata_q;

   // ============================================================
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_port_read;
      op_valid_i && !op_write_i && ind_to_port;
   endsequence
   sequence s_zero_answer;
      ##2 (op_rvalid_o && op_zero_o && op_rdata_o == 8'h00);
   endsequence
   sequence s_unimpl_read;
      op_valid_i && !op_write_i && unimpl && !ind_to_port;
   endsequence

   AST_PORT_READ_ZERO: assert property (s_port_read |-> s_zero_answer)
      else $error("port read through pointer did not give zero");
   AST_PORT_WRITE_NOP: assert property (op_valid_i && op_write_i && ind_to_port
      |=> !mem_we_o && op_status_keep_o && $stable(bank_select_q)) else $error("port write was not a no-op");
   AST_UNIMPL_READ_ZERO: assert property (s_unimpl_read |-> ##2 (op_rvalid_o && op_rdata_o == 8'h00 && !op_zero_o))
      else $error("unimplemented bank read not zero");
   AST_UNIMPL_NO_WRITE: assert property (op_valid_i && op_write_i && unimpl
      |=> !mem_we_o && !mem_re_o) else $error("unimplemented bank was written");
   AST_BSEL_UPPER_ZERO: assert property (reg_re_i && reg_addr_i == REG_BANK_SELECT
      |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3:0] == $past(bank_select_q)) else $error("bank select readback wrong");
   AST_BANKED_ADDR: assert property (op_valid_i && op_access_i && !op_abs_i && !hit_port
      |=> mem_addr_o == {$past(bank_select_q), $past(op_offset_i)}) else $error("banked address wrong");
   AST_ACCESS_ADDR: assert property (op_valid_i && !op_access_i && !op_abs_i && !hit_port
      |=> mem_addr_o[11:8] == (($past(op_offset_i) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : SFR_BANK)
          && mem_addr_o[7:0] == $past(op_offset_i)) else $error("access bank address wrong");
   AST_ABS_ADDR: assert property (op_valid_i && op_abs_i && !hit_port
      |=> mem_addr_o == $past(op_abs_addr_i)) else $error("full-address move used bank select");
   AST_INDEXED_ADDR: assert property (op_valid_i && hit_port && port_mode == DMAU_M_INDEXED
      |=> mem_addr_o == $past(ptr_w[port_sel]) + {{4{$past(wacc_i[7])}}, $past(wacc_i)})
      else $error("indexed address wrong");
   AST_PRE_INC_ADDR: assert property (op_valid_i && hit_port && port_mode == DMAU_M_PRE_INC
      |=> mem_addr_o == $past(ptr_w[port_sel]) + 12'h001) else $error("pre-increment address wrong");

endmodule

// *** verif/dmau_ram_model.sv ***
`timescale 1ns/1ps
// ============================================================
// data ram standing behind the address unit
module dmau_ram_model (
   // clock
   input wire logic ref_clk_i,
   // ram port
   input wire logic [11:0] mem_addr_i,
   input wire logic mem_we_i,
   input wire logic mem_re_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem_q [0:4095];
   logic tog_q = 1'h0;
   // preload a pattern tied to the address so a wrong address reads wrong data
   initial begin
      for (int a = 0; a < 4096; a++) begin
         mem_q[a] = 8'(a) ^ {4'(a >> 8), 4'(a >> 8)};
      end
   end
   always @(posedge ref_clk_i) begin
      tog_q <= ~tog_q;
      if (mem_we_i) begin
         mem_q[mem_addr_i] <= mem_wdata_i;
      end
   end
   // outside a read strobe the bus keeps changing, never a stale value
   assign mem_rdata_o = mem_re_i ? mem_q[mem_addr_i] : {8{tog_q}};
endmodule

// *** verif/tb_data_memory_address_unit.sv ***
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the data memory address unit
module tb_data_memory_address_unit;
   import dmau_pkg::*;
   logic ref_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic op_valid_i = 1'h0, op_write_i = 1'h0, op_access_i = 1'h0, op_abs_i = 1'h0;
   logic [7:0] op_offset_i = 8'h00, op_wdata_i = 8'h00, wacc_i = 8'h00, op_rdata_o, mem_wdata_o, mem_rdata_i;
   logic [11:0] op_abs_addr_i = 12'h000, mem_addr_o;
   logic op_rvalid_o, op_zero_o, op_status_keep_o, mem_we_o, mem_re_o;
   logic [2:0] reg_addr_i = 3'h0;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
   logic reg_we_i = 1'h0, reg_re_i = 1'h0;
   int err_total = 0;
   int total_checks = 0;

   // ============================================================
   // design and ram
   // only four banks fitted, so banks 4..14 stay unimplemented
   dmau_addr_unit #(.DATA_BANKS(4)) DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i),
      .op_write_i(op_write_i), .op_access_i(op_access_i), .op_abs_i(op_abs_i), .op_offset_i(op_offset_i),
      .op_abs_addr_i(op_abs_addr_i), .op_wdata_i(op_wdata_i), .wacc_i(wacc_i), .op_rvalid_o(op_rvalid_o),
      .op_rdata_o(op_rdata_o), .op_zero_o(op_zero_o), .op_status_keep_o(op_status_keep_o),
      .mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));
   dmau_ram_model ram (.ref_clk_i(ref_clk_i), .mem_addr_i(mem_addr_o), .mem_we_i(mem_we_o),
      .mem_re_i(mem_re_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // ============================================================
   // helpers
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction

   task automatic chk(input logic c, input string m);
      total_checks++;
      if (!c) begin
         err_total++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask

   // one operand access; hit = ram strobe expected, pk = indirect target is a port
   task automatic op(input logic w, a, ab, input logic [7:0] off, input logic [11:0] aa,
                     input logic [7:0] wd, input logic hit, pk, input logic [11:0] ea);
      @(posedge ref_clk_i);
      op_valid_i <= 1'h1;
      op_write_i <= w;
      op_access_i <= a;
      op_abs_i <= ab;
      op_offset_i <= off;
      op_abs_addr_i <= aa;
      op_wdata_i <= wd;
      @(posedge ref_clk_i);
      op_valid_i <= 1'h0;
      #1;
      chk(mem_re_o === (hit & ~w) && mem_we_o === (hit & w), "ram strobe");
      if (hit) chk(mem_addr_o === ea, "ram address");
      if (hit & w) chk(mem_wdata_o === wd, "ram write data");
      if (w) chk(op_status_keep_o === pk, "status keep");
      @(posedge ref_clk_i);
      #1;
      if (!w) chk(op_rvalid_o === 1'h1 && op_rdata_o === (hit ? pat(ea) : 8'h00) && op_zero_o === pk, "read answer");
      else chk(op_rvalid_o === 1'h0 && op_zero_o === 1'h0, "no answer to a write");
   endtask

   task automatic reg_wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_we_i <= 1'h1;
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_we_i <= 1'h0;
   endtask

   task automatic reg_rd(input logic [2:0] ad, input logic [7:0] e);
      @(posedge ref_clk_i);
      reg_re_i <= 1'h1;
      reg_addr_i <= ad;
      @(posedge ref_clk_i);
      reg_re_i <= 1'h0;
      #1;
      chk(reg_rdata_o === e, "register read");
   endtask

   // ============================================================
   // scenarios
   task automatic t_bank_select();
      reg_rd(3'h0, 8'h00);
      reg_wr(3'h0, 8'hFF);
      reg_rd(3'h0, 8'h0F);
   endtask

   task automatic t_direct();
      reg_wr(3'h0, 8'h02);
      op(1'h0, 1'h1, 1'h0, 8'h34, 12'h000, 8'h00, 1'h1, 1'h0, 12'h234);
      op(1'h1, 1'h1, 1'h0, 8'hFF, 12'h000, 8'h5A, 1'h1, 1'h0, 12'h2FF);
      op(1'h0, 1'h0, 1'h0, 8'h7F, 12'h000, 8'h00, 1'h1, 1'h0, 12'h07F);
      op(1'h0, 1'h0, 1'h0, 8'h80, 12'h000, 8'h00, 1'h1, 1'h0, 12'hF80);
   endtask

   task automatic t_unimplemented();
      reg_wr(3'h0, 8'h09);
      op(1'h0, 1'h1, 1'h0, 8'h10, 12'h000, 8'h00, 1'h0, 1'h0, 12'h910);
      reg_rd(3'h7, 8'h01);
      op(1'h1, 1'h1, 1'h0, 8'h11, 12'h000, 8'hC3, 1'h0, 1'h0, 12'h911);
      op(1'h0, 1'h1, 1'h1, 8'h10, 12'h123, 8'h00, 1'h1, 1'h0, 12'h123);
   endtask

   task automatic t_pointer_modes();
      @(posedge ref_clk_i);
      wacc_i <= 8'hFE;
      reg_wr(3'h1, 8'hFF);
      reg_wr(3'h2, 8'h00);
      op(1'h0, 1'h0, 1'h0, 8'hEE, 12'h000, 8'h00, 1'h1, 1'h0, 12'h0FF);
      reg_rd(3'h1, 8'h00);
      reg_rd(3'h2, 8'h01);
      op(1'h0, 1'h0, 1'h0, 8'hEC, 12'h000, 8'h00, 1'h1, 1'h0, 12'h101);
      op(1'h0, 1'h0, 1'h0, 8'hED, 12'h000, 8'h00, 1'h1, 1'h0, 12'h101);
      op(1'h0, 1'h0, 1'h0, 8'hEF, 12'h000, 8'h00, 1'h1, 1'h0, 12'h100);
      op(1'h0, 1'h0, 1'h0, 8'hEB, 12'h000, 8'h00, 1'h1, 1'h0, 12'h0FE);
      reg_rd(3'h1, 8'h00);
      reg_wr(3'h5, 8'h34);
      reg_wr(3'h6, 8'hFF);
      reg_rd(3'h6, 8'h0F);
      op(1'h0, 1'h0, 1'h0, 8'hDF, 12'h000, 8'h00, 1'h1, 1'h0, 12'hF34);
      reg_rd(3'h4, 8'h00);
   endtask

   task automatic t_port_targets();
      reg_wr(3'h3, 8'hEF);
      reg_wr(3'h4, 8'h0F);
      op(1'h0, 1'h0, 1'h0, 8'hE7, 12'h000, 8'h00, 1'h0, 1'h1, 12'hFEF);
      reg_rd(3'h7, 8'h02);
      op(1'h1, 1'h0, 1'h0, 8'hE7, 12'h000, 8'h77, 1'h0, 1'h1, 12'hFEF);
   endtask

   task automatic t_wrap_and_priority();
      reg_wr(3'h1, 8'hFF);
      reg_wr(3'h2, 8'h0F);
      op(1'h0, 1'h0, 1'h0, 8'hEE, 12'h000, 8'h00, 1'h1, 1'h0, 12'hFFF);
      reg_rd(3'h1, 8'h00);
      reg_rd(3'h2, 8'h00);
      reg_wr(3'h1, 8'hE9);
      // the wrap above cleared the high byte; aim the pointer at its own low byte again
      reg_wr(3'h2, 8'h0F);
      op(1'h1, 1'h0, 1'h0, 8'hEE, 12'h000, 8'h55, 1'h0, 1'h0, 12'hFE9);
      reg_rd(3'h1, 8'h55);
      reg_rd(3'h2, 8'h0F);
   endtask

   // ============================================================
   // run control
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // whole run is about a hundred cycles; the 5000-cycle limit, near fifty times that, means a hang
   initial begin
      #(25 * 5000);
      err_total++;
      print_verdict();
   end

   initial begin
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'h0;
      t_bank_select();
      t_direct();
      t_unimplemented();
      t_pointer_modes();
      t_port_targets();
      t_wrap_and_priority();
      print_verdict();
   end
endmodule
